// file: verilog/i2crs_consts.svh
`ifndef I2CRS_CONSTS_SVH
`define I2CRS_CONSTS_SVH

// command codes in command byte 0
`define I2CRS_OP_WR 3'h3
`define I2CRS_OP_RD 3'h4

// slave address setting, port 0 offset 294h
`define I2CRS_SADDR_OFS 12'h294
`define I2CRS_SADDR_DW 10'h0A5
`define I2CRS_SADDR_RST 32'h0000005F

// packet byte counts after the address byte
`define I2CRS_CNT_CMD 4'h4
`define I2CRS_CNT_DATA 4'h8
`define I2CRS_CNT_SURPLUS 4'h9

// controller register offsets
`define I2CRS_R_CTRL 8'h00
`define I2CRS_R_ADDR 8'h04
`define I2CRS_R_WDATA 8'h08
`define I2CRS_R_RDATA 8'h0C
`define I2CRS_R_STAT 8'h10

// fields of the controller address register
`define I2CRS_F_DW 2
`define I2CRS_F_PORT 12
`define I2CRS_F_BE 15
`define I2CRS_F_SA 19

// timing: link clock period and the hclk period, both in ns
`define I2CRS_SCL_NS 800
`define I2CRS_CLK_NS 8
`define I2CRS_QTR ((`I2CRS_SCL_NS / 4) / `I2CRS_CLK_NS)

`endif

// file: verilog/i2crs_pkg.sv
package i2crs_pkg;

  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_RACK, DS_TX, DS_TACK} i2crs_dst_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} i2crs_hst_t;

endpackage

// file: verilog/i2crs_if.sv
`timescale 1ns/1ps
`default_nettype none

interface i2crs_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // open-drain data wire with pull-up; clock driven by the host, pulled up when released
  assign scl = host_scl_oe_n ? 1'h1 : host_scl_o;
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input sda, output host_scl_o, output host_scl_oe_n,
                output host_sda_o, output host_sda_oe_n);
endinterface

`default_nettype wire

// file: verilog/i2crs_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2crs_consts.svh"

module i2crs_dev
  import i2crs_pkg::*;
(
  i2crs_if.dev              lnk,
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [2:0]   addr_strap,
  input  wire logic [2:0]   addr_strap_oe,
  input  wire logic         cfg_we,
  input  wire logic [31:0]  cfg_wdata,
  output logic      [6:0]   slave_addr_q
);

  i2crs_dst_t  state_q;
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  logic [5:0]  strap_m_q;
  logic [5:0]  strap_s_q;
  logic [3:0]  bit_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic [1:0]  ridx_q;
  logic        rd_q;
  logic        ackok_q;
  logic        sda_oe_n_q;
  logic [31:0] cmd_q;
  logic [31:0] wd_q;
  logic [31:0] rbuf_q;
  logic [31:0] cfg_q;
  logic [31:0] mem_q [0:63];
  logic [31:0] rd_word;

  // index 0 first stage, 1 second stage, 2 previous sample
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_c  = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire stop_c   = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  // command fields
  wire [2:0] op     = cmd_q[26:24];
  wire [2:0] port   = {cmd_q[17:16], cmd_q[15]};
  wire [3:0] be     = cmd_q[13:10];
  wire [9:0] dw     = cmd_q[9:0];
  wire       valid  = ~port[2] & ((op == `I2CRS_OP_WR) | (op == `I2CRS_OP_RD));
  wire       is_cfg = (port == 3'h0) & (dw == `I2CRS_SADDR_DW);
  wire       is_mem = (dw[9:4] == 6'h0);
  wire [5:0] midx   = {port[1:0], dw[3:0]};
  wire       rack_end = (state_q == DS_RACK) & scl_fall;
  wire       commit = rack_end & (cnt_q == `I2CRS_CNT_DATA) & valid
                      & (op == `I2CRS_OP_WR);
  wire       latch  = rack_end & (cnt_q == `I2CRS_CNT_CMD) & valid
                      & (op == `I2CRS_OP_RD);
  wire [1:0] ridx_n = ridx_q - 2'h1;
  wire [7:0] nxt_b  = rbuf_q[{ridx_n, 3'h0} +: 8];

  assign lnk.dev_sda_o    = 1'h0;
  assign lnk.dev_sda_oe_n = sda_oe_n_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  en);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (en[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb
  begin
    if (is_cfg)
    begin
      rd_word = cfg_q;
    end
    else if (is_mem)
    begin
      rd_word = mem_q[midx];
    end
    else
    begin
      rd_word = 32'h0;
    end
  end

  // pin synchronisers and strap capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_q        <= 3'h7;
      sda_q        <= 3'h7;
      strap_m_q    <= 6'h07;
      strap_s_q    <= 6'h07;
      slave_addr_q <= 7'h5F;
    end
    else
    begin
      scl_q        <= {scl_q[1:0], lnk.scl};
      sda_q        <= {sda_q[1:0], lnk.sda};
      strap_m_q    <= {addr_strap_oe, addr_strap};
      strap_s_q    <= strap_m_q;
      slave_addr_q <= {cfg_q[6:3], strap_s_q[2:0] | ~strap_s_q[5:3]};
    end
  end

  // register store; cfg_q also loaded by cfg_we, but a link commit to it in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q  <= `I2CRS_SADDR_RST;
      rbuf_q <= 32'h0;
      for (int i = 0; i < 64; i++)
      begin
        mem_q[i] <= 32'h0;
      end
    end
    else
    begin
      if (cfg_we)
      begin
        cfg_q <= cfg_wdata;
      end
      if (commit)
      begin
        if (is_cfg)
        begin
          cfg_q <= merge(cfg_q, wd_q, be);
        end
        else if (is_mem)
        begin
          mem_q[midx] <= merge(mem_q[midx], wd_q, be);
        end
      end
      if (latch)
      begin
        rbuf_q <= rd_word;
      end
    end
  end

  // byte engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q    <= DS_IDLE;
      bit_q      <= 4'h0;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h0;
      tx_q       <= 8'h0;
      ridx_q     <= 2'h3;
      rd_q       <= 1'h0;
      ackok_q    <= 1'h0;
      sda_oe_n_q <= 1'h1;
      cmd_q      <= 32'h0;
      wd_q       <= 32'h0;
    end
    else if (start_c)
    begin
      state_q    <= DS_RX;
      bit_q      <= 4'h0;
      cnt_q      <= 4'h0;
      sda_oe_n_q <= 1'h1;
    end
    else if (stop_c)
    begin
      state_q    <= DS_IDLE;
      sda_oe_n_q <= 1'h1;
    end
    else
    begin
      case (state_q)
        DS_RX:
        begin
          if (scl_rise)
          begin
            sh_q  <= {sh_q[6:0], sda_q[1]};
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == 4'h8)
          begin
            state_q <= DS_RACK;
            bit_q   <= 4'h0;
            if (cnt_q == 4'h0)
            begin
              rd_q <= sh_q[0];
              if (sh_q[7:1] == slave_addr_q)
              begin
                sda_oe_n_q <= 1'h0;
              end
              else
              begin
                state_q <= DS_IDLE;
              end
            end
            else if (cnt_q <= `I2CRS_CNT_CMD)
            begin
              sda_oe_n_q <= 1'h0;
              cmd_q      <= {cmd_q[23:0], sh_q};
            end
            else if (cnt_q <= `I2CRS_CNT_DATA)
            begin
              sda_oe_n_q <= 1'h0;
              wd_q       <= {wd_q[23:0], sh_q};
            end
            // surplus byte: line left released, master sees a not-acknowledge
          end
        end
        DS_RACK:
        begin
          if (scl_fall)
          begin
            sda_oe_n_q <= 1'h1;
            cnt_q      <= (cnt_q == `I2CRS_CNT_SURPLUS) ? cnt_q : cnt_q + 4'h1;
            if (cnt_q == 4'h0 && rd_q)
            begin
              state_q    <= DS_TX;
              ridx_q     <= 2'h3;
              tx_q       <= rbuf_q[31:24];
              sda_oe_n_q <= rbuf_q[31];
            end
            else
            begin
              state_q <= DS_RX;
            end
          end
        end
        DS_TX:
        begin
          if (scl_rise)
          begin
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_fall)
          begin
            if (bit_q == 4'h8)
            begin
              sda_oe_n_q <= 1'h1;
              state_q    <= DS_TACK;
            end
            else
            begin
              tx_q       <= {tx_q[6:0], 1'h0};
              sda_oe_n_q <= tx_q[6];
            end
          end
        end
        DS_TACK:
        begin
          if (scl_rise)
          begin
            ackok_q <= ~sda_q[1];
          end
          else if (scl_fall)
          begin
            if (ackok_q)
            begin
              state_q    <= DS_TX;
              bit_q      <= 4'h0;
              ridx_q     <= ridx_n;
              tx_q       <= nxt_b;
              sda_oe_n_q <= nxt_b[7];
            end
            else
            begin
              state_q <= DS_IDLE;
            end
          end
        end
        default:
        begin
          sda_oe_n_q <= 1'h1;
        end
      endcase
    end
  end

endmodule // i2crs_dev

`default_nettype wire

// file: verilog/i2crs_host.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "i2crs_consts.svh"

module i2crs_host
  import i2crs_pkg::*;
(
  i2crs_if.host             lnk,
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic      [31:0]  hrdata,
  output logic              hresp
);

  localparam logic [15:0] QTR = 16'(`I2CRS_QTR);

  i2crs_hst_t  hst_q;
  logic [15:0] qc_q;
  logic [1:0]  ph_q;
  logic [3:0]  bidx_q;
  logic [3:0]  bitn_q;
  logic [7:0]  sh_q;
  logic        ackn_q;
  logic        restart_q;
  logic        nak_q;
  logic [31:0] rdata_q;
  logic        scl_o_q;
  logic        sda_oe_n_q;
  logic [1:0]  sda_q;
  logic        wp_q;
  logic [7:0]  wa_q;
  logic [31:0] hrdata_q;
  logic [31:0] areg_q;
  logic [31:0] wdat_q;
  logic        go_q;
  logic        rd_q;
  logic        refused_q;
  logic [31:0] rmux;

  wire       tick    = (qc_q == QTR - 16'h1);
  wire       rx_byte = (bidx_q > 4'h9);
  wire       busy    = (hst_q != HS_IDLE);
  wire [9:0] dw      = areg_q[`I2CRS_F_DW +: 10];
  wire [2:0] port    = areg_q[`I2CRS_F_PORT +: 3];
  wire [3:0] be      = areg_q[`I2CRS_F_BE +: 4];
  wire [6:0] sa      = areg_q[`I2CRS_F_SA +: 7];
  wire       take    = hsel & htrans[1] & hready;

  assign lnk.host_scl_o    = scl_o_q;
  assign lnk.host_scl_oe_n = 1'h0;
  assign lnk.host_sda_o    = 1'h0;
  assign lnk.host_sda_oe_n = sda_oe_n_q;
  assign hrdata    = hrdata_q;
  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;

  function automatic logic [7:0] txb(input logic [3:0] i);
    case (i)
      4'h0:    return {sa, 1'h0};
      4'h1:    return {5'h0, rd_q ? `I2CRS_OP_RD : `I2CRS_OP_WR};
      4'h2:    return {6'h0, port[2:1]};
      4'h3:    return {port[0], 1'h0, be, dw[9:8]};
      4'h4:    return dw[7:0];
      4'h5:    return wdat_q[31:24];
      4'h6:    return wdat_q[23:16];
      4'h7:    return wdat_q[15:8];
      4'h8:    return wdat_q[7:0];
      4'h9:    return {sa, 1'h1};
      default: return 8'h0;
    endcase
  endfunction

  always_comb
  begin
    if (haddr[7:0] == `I2CRS_R_CTRL)
    begin
      rmux = {30'h0, rd_q, 1'h0};
    end
    else if (haddr[7:0] == `I2CRS_R_ADDR)
    begin
      rmux = areg_q;
    end
    else if (haddr[7:0] == `I2CRS_R_WDATA)
    begin
      rmux = wdat_q;
    end
    else if (haddr[7:0] == `I2CRS_R_RDATA)
    begin
      rmux = rdata_q;
    end
    else if (haddr[7:0] == `I2CRS_R_STAT)
    begin
      rmux = {29'h0, refused_q, nak_q, busy};
    end
    else
    begin
      rmux = 32'h0;
    end
  end

  // bus slave: zero wait states, read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp_q      <= 1'h0;
      wa_q      <= 8'h0;
      hrdata_q  <= 32'h0;
      areg_q    <= 32'h0;
      wdat_q    <= 32'h0;
      go_q      <= 1'h0;
      rd_q      <= 1'h0;
      refused_q <= 1'h0;
    end
    else
    begin
      go_q <= 1'h0;
      wp_q <= take & hwrite;
      if (take)
      begin
        wa_q <= haddr[7:0];
      end
      // read data registered at the address phase so it stands in the data phase
      if (take && !hwrite)
      begin
        hrdata_q <= rmux;
      end
      if (wp_q && wa_q == `I2CRS_R_CTRL)
      begin
        if (hwdata[0] && !busy && !go_q)
        begin
          if (!hwdata[1] && port == 3'h0 && dw == `I2CRS_SADDR_DW)
          begin
            refused_q <= 1'h1;
          end
          else
          begin
            go_q      <= 1'h1;
            rd_q      <= hwdata[1];
            refused_q <= 1'h0;
          end
        end
      end
      else if (wp_q && wa_q == `I2CRS_R_ADDR)
      begin
        areg_q <= hwdata;
      end
      else if (wp_q && wa_q == `I2CRS_R_WDATA)
      begin
        wdat_q <= hwdata;
      end
    end
  end

  // link engine: quarter-period phases, scl low in 0..1, rises at end of 1, high in 2..3, falls at end of 3
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hst_q      <= HS_IDLE;
      qc_q       <= 16'h0;
      ph_q       <= 2'h0;
      bidx_q     <= 4'h0;
      bitn_q     <= 4'h0;
      sh_q       <= 8'h0;
      ackn_q     <= 1'h0;
      restart_q  <= 1'h0;
      nak_q      <= 1'h0;
      rdata_q    <= 32'h0;
      scl_o_q    <= 1'h1;
      sda_oe_n_q <= 1'h1;
      sda_q      <= 2'h3;
    end
    else
    begin
      sda_q <= {sda_q[0], lnk.sda};
      qc_q  <= (hst_q == HS_IDLE || tick) ? 16'h0 : qc_q + 16'h1;
      if (hst_q != HS_IDLE && tick)
      begin
        ph_q <= ph_q + 2'h1;
      end
      case (hst_q)
        HS_IDLE:
        begin
          if (go_q)
          begin
            hst_q     <= HS_START;
            ph_q      <= 2'h0;
            bidx_q    <= 4'h0;
            sh_q      <= txb(4'h0);
            nak_q     <= 1'h0;
            restart_q <= 1'h0;
          end
        end
        HS_START:
        begin
          if (tick && ph_q == 2'h1)
          begin
            sda_oe_n_q <= 1'h0;
          end
          else if (tick && ph_q == 2'h3)
          begin
            scl_o_q <= 1'h0;
            hst_q   <= HS_BIT;
            bitn_q  <= 4'h0;
          end
        end
        HS_BIT:
        begin
          if (tick && ph_q == 2'h0)
          begin
            sda_oe_n_q <= (bitn_q != 4'h8) ? (rx_byte | sh_q[7])
                                           : (~rx_byte | (bidx_q == 4'hD));
          end
          else if (tick && ph_q == 2'h1)
          begin
            scl_o_q <= 1'h1;
          end
          else if (tick && ph_q == 2'h2)
          begin
            if (bitn_q != 4'h8 && rx_byte)
            begin
              sh_q <= {sh_q[6:0], sda_q[1]};
            end
            ackn_q <= sda_q[1];
          end
          else if (tick && ph_q == 2'h3)
          begin
            scl_o_q <= 1'h0;
            if (bitn_q != 4'h8)
            begin
              bitn_q <= bitn_q + 4'h1;
              if (!rx_byte)
              begin
                sh_q <= {sh_q[6:0], 1'h0};
              end
            end
            else
            begin
              bitn_q <= 4'h0;
              if (rx_byte)
              begin
                rdata_q <= {rdata_q[23:0], sh_q};
              end
              if (!rx_byte && ackn_q)
              begin
                nak_q <= 1'h1;
                hst_q <= HS_STOP;
              end
              else if ((!rd_q && bidx_q == 4'h8) || bidx_q == 4'hD)
              begin
                hst_q <= HS_STOP;
              end
              else if (rd_q && bidx_q == 4'h4)
              begin
                hst_q     <= HS_STOP;
                restart_q <= 1'h1;
              end
              else
              begin
                bidx_q <= bidx_q + 4'h1;
                sh_q   <= txb(bidx_q + 4'h1);
              end
            end
          end
        end
        default:
        begin
          if (tick && ph_q == 2'h0)
          begin
            sda_oe_n_q <= 1'h0;
          end
          else if (tick && ph_q == 2'h1)
          begin
            scl_o_q <= 1'h1;
          end
          else if (tick && ph_q == 2'h2)
          begin
            sda_oe_n_q <= 1'h1;
          end
          else if (tick && ph_q == 2'h3)
          begin
            hst_q     <= restart_q ? HS_START : HS_IDLE;
            restart_q <= 1'h0;
            bidx_q    <= 4'h9;
            sh_q      <= txb(4'h9);
          end
        end
      endcase
    end
  end

endmodule // i2crs_host

`default_nettype wire

// file: verif/i2crs_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2crs_consts.svh"

module i2crs_props
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n
);
  localparam int MIN_PH = `I2CRS_QTR - 2;

  logic        scl_q;
  logic        sda_q;
  logic        frame_q;
  logic        first_q;
  logic [3:0]  bit_q;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic        start_w;
  logic        stop_w;

  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w  = scl && scl_q && !sda_q && sda;

  // wire history and frame tracking
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      scl_q   <= 1'h1;
      sda_q   <= 1'h1;
      frame_q <= 1'h0;
    end
    else
    begin
      scl_q   <= scl;
      sda_q   <= sda;
      frame_q <= start_w ? 1'h1 : (stop_w ? 1'h0 : frame_q);
    end

  // bit slot within the byte, 9 is the acknowledge slot
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bit_q   <= 4'h0;
      first_q <= 1'h0;
    end
    else if (start_w)
    begin
      bit_q   <= 4'h0;
      first_q <= 1'h1;
    end
    else
    begin
      if (scl && !scl_q)
        bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
      if (!scl && scl_q && bit_q == 4'h9)
        first_q <= 1'h0;
    end

  // length of the high and low clock phases
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hi_q <= 16'h0;
      lo_q <= 16'h0;
    end
    else
    begin
      hi_q <= !scl ? 16'h0 : (hi_q == 16'hFFFF ? hi_q : hi_q + 16'h1);
      lo_q <= scl ? 16'h0 : (lo_q == 16'hFFFF ? lo_q : lo_q + 16'h1);
    end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_dev_edge_low: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device moved data while clock high");
  a_dev_idle_quiet: assert property (!frame_q |-> dev_sda_oe_n)
    else $error("device pulled data outside a frame");
  a_ack_slot_only: assert property (first_q && scl && scl_q && !dev_sda_oe_n |-> bit_q == 4'h9)
    else $error("device pulled data in address byte outside ack slot");
  a_host_ack_free: assert property (first_q && scl && scl_q && bit_q == 4'h9 |-> host_sda_oe_n)
    else $error("host held data in address ack slot");
  a_no_collide: assert property (scl && !dev_sda_oe_n |-> host_sda_oe_n)
    else $error("both ends pulled data together");
  a_scl_high_min: assert property ($fell(scl) |-> hi_q >= MIN_PH)
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($rose(scl) |-> lo_q >= MIN_PH)
    else $error("clock low phase too short");
  a_idle_scl_high: assert property (!frame_q && !$past(frame_q) |-> scl)
    else $error("clock not standing high between frames");

  c_start: cover property (start_w);
  c_ack: cover property (first_q && bit_q == 4'h9 && scl && !dev_sda_oe_n);
  c_read_data: cover property (frame_q && !first_q && scl && bit_q < 4'h9 && !dev_sda_oe_n);
  c_stop: cover property (stop_w);
endmodule // i2crs_props

`default_nettype wire

// file: verif/i2c_slave_register_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2crs_consts.svh"

module i2c_slave_register_access_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  addr_strap;
  logic [2:0]  addr_strap_oe;
  logic        cfg_we;
  logic [31:0] cfg_wdata;
  logic [6:0]  slave_addr_q;
  logic [31:0] st;
  logic [31:0] rd;
  int          mismatches;
  int          check_count;
  int          cyc = 0;

  i2crs_if lnk ();

  i2crs_host i_i2crs_host (.lnk(lnk), .hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  i2crs_dev i_i2crs_dev (.lnk(lnk), .hclk(hclk), .hresetn(hresetn), .addr_strap(addr_strap),
    .addr_strap_oe(addr_strap_oe), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
    .slave_addr_q(slave_addr_q));

  i2crs_props i_i2crs_props (.hclk(hclk), .hresetn(hresetn), .scl(lnk.scl), .sda(lnk.sda),
    .host_sda_oe_n(lnk.host_sda_oe_n), .dev_sda_oe_n(lnk.dev_sda_oe_n));

  initial
  begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one single word transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  // one link transfer through the host registers; final status lands in st
  task run(input logic rdir, input logic [2:0] port, input logic [9:0] dw,
           input logic [3:0] be, input logic [31:0] wd, input logic [6:0] sa);
    ahb(1'h1, `I2CRS_R_ADDR, {6'h0, sa, be, port, dw, 2'h0});
    ahb(1'h1, `I2CRS_R_WDATA, wd);
    ahb(1'h1, `I2CRS_R_CTRL, {30'h0, rdir, 1'h1});
    repeat (2) @(posedge hclk);
    do ahb(1'h0, `I2CRS_R_STAT, 32'h0); while (rd[0] !== 1'h0);
    st = rd;
  endtask

  task set_cfg(input logic [31:0] v);
    cfg_we    <= 1'h1;
    cfg_wdata <= v;
    @(posedge hclk);
    cfg_we    <= 1'h0;
    repeat (4) @(posedge hclk);
  endtask

  task t_reset;
    check({25'h0, slave_addr_q}, 32'h5F);
    check({31'h0, hresp}, 32'h0);
    ahb(1'h0, `I2CRS_R_STAT, 32'h0);
    check(rd, 32'h0);
    ahb(1'h0, 8'h20, 32'h0);
    check(rd, 32'h0);
  endtask

  task t_straps;
    addr_strap_oe <= 3'h7;
    addr_strap    <= 3'h2;
    repeat (4) @(posedge hclk);
    check({25'h0, slave_addr_q}, 32'h5A);
    addr_strap_oe <= 3'h0;
    repeat (4) @(posedge hclk);
    check({25'h0, slave_addr_q}, 32'h5F);
  endtask

  task t_cfg_addr;
    set_cfg(32'h28);
    check({25'h0, slave_addr_q}, 32'h2F);
    run(1'h0, 3'h0, 10'h3, 4'hF, 32'h0, 7'h5F);
    check({31'h0, st[1]}, 32'h1);
    set_cfg(32'h5F);
  endtask

  task t_write_read;
    run(1'h0, 3'h1, 10'h3, 4'h5, 32'h12345678, 7'h5F);
    check({29'h0, st[2:0]}, 32'h0);
    run(1'h1, 3'h1, 10'h3, 4'hF, 32'h0, 7'h5F);
    ahb(1'h0, `I2CRS_R_RDATA, 32'h0);
    check(rd, 32'h00340078);
  endtask

  task t_invalid;
    run(1'h0, 3'h4, 10'h3, 4'hF, 32'hFFFFFFFF, 7'h5F);
    run(1'h1, 3'h0, 10'h3, 4'hF, 32'h0, 7'h5F);
    ahb(1'h0, `I2CRS_R_RDATA, 32'h0);
    check(rd, 32'h0);
  endtask

  task t_refuse;
    run(1'h0, 3'h0, 10'h0A5, 4'hF, 32'h0, 7'h5F);
    check({29'h0, st[2:0]}, 32'h4);
    check({25'h0, slave_addr_q}, 32'h5F);
  endtask

  // each complete link transfer costs about nine thousand cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      stop_test;
    end
  end

  initial
  begin
    hresetn       = 1'h0;
    hsel          = 1'h0;
    htrans        = 2'h0;
    hwrite        = 1'h0;
    hsize         = 3'h2;
    haddr         = 32'h0;
    hwdata        = 32'h0;
    addr_strap    = 3'h7;
    addr_strap_oe = 3'h0;
    cfg_we        = 1'h0;
    cfg_wdata     = 32'h0;
    mismatches    = 0;
    check_count   = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset;
    t_straps;
    t_cfg_addr;
    t_write_read;
    t_invalid;
    t_refuse;
    stop_test;
  end
endmodule // i2c_slave_register_access_tb

`default_nettype wire
